/* adctr_pkg.sv */
// Constants and types shared by the converter trigger and control block
package adctr_pkg;

   // Register bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets (bus word index)
   localparam logic [3:0] OFF_RES_HI = 4'h0;
   localparam logic [3:0] OFF_RES_LO = 4'h1;
   localparam logic [3:0] OFF_CTRL_FIRST = 4'h2;
   localparam logic [3:0] OFF_CTRL_SECOND = 4'h3;
   localparam logic [3:0] OFF_PFLAGS1 = 4'h4;
   localparam logic [3:0] OFF_PENABLES1 = 4'h5;
   localparam logic [3:0] OFF_PPRIO1 = 4'h6;
   localparam logic [3:0] OFF_PPRIO2 = 4'h7;

   // Field positions of the first control register
   localparam int CF_CLK_HI = 7;
   localparam int CF_CLK_LO = 6;
   localparam int CF_CHS_HI = 5;
   localparam int CF_CHS_LO = 3;
   localparam int CF_GO = 2;
   localparam int CF_ZERO = 1;
   localparam int CF_ON = 0;

   // Field positions of the second control register
   localparam int CS_JUSTIFY = 7;
   localparam int CS_CLK2 = 6;
   localparam int CS_PCFG_HI = 3;
   localparam int CS_PCFG_LO = 0;

   // Converter bit in the peripheral flag, enable and priority registers
   localparam int IRQ_BIT = 6;

   // Writable bits of the control registers
   localparam logic [7:0] CTRL_FIRST_WMASK = 8'hfd;
   localparam logic [7:0] CTRL_SECOND_WMASK = 8'hcf;

   // Values after reset
   localparam logic [7:0] CTRL_FIRST_RST = 8'h00;
   localparam logic [7:0] CTRL_SECOND_RST = 8'h00;
   localparam logic [7:0] PFLAGS1_RST = 8'h00;
   localparam logic [7:0] PENABLES1_RST = 8'h00;
   localparam logic [7:0] PPRIO1_RST = 8'h00;
   localparam logic [4:0] PPRIO2_RST_POR = 5'h1f;
   localparam logic [4:0] PPRIO2_RST_OTHER = 5'h10;

   // Compare unit mode that issues the special-event trigger
   localparam logic [3:0] TRIG_MODE = 4'hb;

   // Conversion timing in bit periods
   localparam logic [3:0] CONV_TADS = 4'hc;
   localparam logic [3:0] WAIT_TADS = 4'h2;

   // Internal RC bit period, derived to clock cycles (rounded down)
   localparam int CLK_NS = 25;
   localparam int RC_TAD_NS = 4000;
   localparam logic [7:0] RC_TAD_CYC = 8'(RC_TAD_NS / CLK_NS);

   // Converter sequencer states
   typedef enum logic [3:0]
   {
      ST_OFF = 4'h1,
      ST_WAIT = 4'h2,
      ST_ACQ = 4'h4,
      ST_CONV = 4'h8
   } adctr_state_t;

endpackage : adctr_pkg

/* adctr_top.sv */
// Converter trigger, sequencer and register file
//
// How it works
// - A special-event trigger starts a conversion only with mode 1011 and the converter on.
// - An accepted trigger sets the go flag just like a software write would.
// - Every special-event trigger pulses the timer clear so acquisition repeats.
// - With the converter off the trigger leaves go alone but still clears the timer.
// - First control: clock select 7-6, channel 5-3, go 2, on 0, bit 1 zero, reset 0.
// - Second control: justify at 7, third clock bit at 6, port config at 3-0.
// - Result bytes are not reset and keep their value across every reset.
// - The converter flag is bit 6 of the first flag register, reset to zero.
// - Enable and priority sit at bit 6 of their registers and reset to zero.
// - Second priority resets to 1 1111 on power-up or brown-out, 1 0000 otherwise, top bits zero.
// - A conversion lasts twelve bit periods of the selected clock.
// - Clearing go mid-conversion aborts it and leaves the results untouched.
// - After end or abort, two bit periods pass before acquisition resumes.
// - Go clears itself when a conversion completes.
`timescale 1ns/100ps

module adctr_top
   import adctr_pkg::*;
(
   input wire logic i_clk, // 40 MHz clock
   input wire logic i_srst, // Synchronous reset, high
   input wire logic i_por_bor, // Reset is power-on or brown-out
   input wire logic i_ce, // Clock enable, freezes all state
   input wire logic [ADDR_W-1:0] i_addr, // Register index
   input wire logic [DATA_W-1:0] i_wdata, // Write data
   input wire logic i_wr, // Write strobe
   input wire logic i_rd, // Read strobe
   output logic [DATA_W-1:0] o_rdata, // Read data, cycle after strobe
   input wire logic [3:0] i_cmp_mode, // Compare unit mode field
   input wire logic i_cmp_event, // Special-event pulse
   input wire logic [9:0] i_sample_data, // Converter core result
   output logic o_timer_clear, // Clear timer counter pulse
   output logic o_sampling, // Acquisition in progress
   output logic o_converting, // Conversion in progress
   output logic [2:0] o_channel, // Selected channel
   output logic [3:0] o_port_config, // Analog pin configuration
   output logic o_irq, // Converter interrupt level
   output logic o_irq_high_prio // Converter priority select
);

   adctr_state_t st_q, st_d;
   logic [7:0] tad_cnt_q, tad_cnt_d;
   logic [3:0] bit_cnt_q, bit_cnt_d;
   logic [7:0] ctrl0_q, ctrl0_d;
   logic [7:0] ctrl1_q, ctrl1_d;
   logic [7:0] pflags_q, pflags_d;
   logic [7:0] pen_q, pen_d;
   logic [7:0] pprio1_q, pprio1_d;
   logic [4:0] pprio2_q, pprio2_d;
   logic [7:0] res_hi_q, res_hi_d;
   logic [7:0] res_lo_q, res_lo_d;
   logic [7:0] rdata_d;
   logic [1:0] clk_sel_lo;
   logic [2:0] tad_shift;
   logic [7:0] tad_len;
   logic tick, trig_event, trig_accept, done, abort, wr_ctrl0, wr_res;
   logic [11:0] dwell_q, dwell_d;

   // Bit period length from the three clock-select bits
   assign clk_sel_lo = ctrl0_q[CF_CLK_HI:CF_CLK_LO];
   assign tad_shift = 3'({clk_sel_lo, 1'b0}) + 3'(ctrl1_q[CS_CLK2]) + 3'h1;
   assign tad_len = (clk_sel_lo == 2'h3) ? RC_TAD_CYC : (8'h01 << tad_shift);
   assign tick = (tad_cnt_q == tad_len - 8'h01);

   // Trigger qualification
   // timer cleared on trigger
   assign trig_event = i_cmp_event && (i_cmp_mode == TRIG_MODE);
   assign trig_accept = trig_event && ctrl0_q[CF_ON];

   // Completion and abort, only judged inside a conversion
   // twelve bit periods
   assign done = (st_q == ST_CONV) && ctrl0_q[CF_GO] && tick
      && (bit_cnt_q == CONV_TADS - 4'h1);
   assign abort = (st_q == ST_CONV) && !ctrl0_q[CF_GO];

   assign wr_ctrl0 = i_wr && (i_addr == OFF_CTRL_FIRST);
   assign wr_res = i_wr && ((i_addr == OFF_RES_HI) || (i_addr == OFF_RES_LO));

   // Sequencer next state; counters restart at every state change
   always_comb
   begin
      st_d = st_q;
      tad_cnt_d = tick ? 8'h00 : tad_cnt_q + 8'h01;
      bit_cnt_d = tick ? bit_cnt_q + 4'h1 : bit_cnt_q;
      case (st_q)
         ST_OFF:
            if (ctrl0_q[CF_ON])
               st_d = ST_ACQ;
         ST_ACQ:
            if (ctrl0_q[CF_GO])
               st_d = ST_CONV;
         ST_CONV:
            if (abort || done)
               st_d = ST_WAIT;
         ST_WAIT:
            if (tick && (bit_cnt_q == WAIT_TADS - 4'h1))
               st_d = ST_ACQ;
         default:
            st_d = ST_OFF;
      endcase
      // Turning the converter off drops any conversion at once
      if (!ctrl0_q[CF_ON])
         st_d = ST_OFF;
      // Free-running counts in idle states are harmless, entry zeroes them
      if (st_d != st_q)
      begin
         tad_cnt_d = 8'h00;
         bit_cnt_d = 4'h0;
      end
   end

   // Sequencer registers; reset acts even with the clock enable low
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         st_q <= ST_OFF;
         tad_cnt_q <= 8'h00;
         bit_cnt_q <= 4'h0;
      end
      else if (i_ce)
      begin
         st_q <= st_d;
         tad_cnt_q <= tad_cnt_d;
         bit_cnt_q <= bit_cnt_d;
      end
   end

   // Register file next values; hardware sets are applied last so they win
   always_comb
   begin
      ctrl0_d = ctrl0_q;
      ctrl1_d = ctrl1_q;
      pflags_d = pflags_q;
      pen_d = pen_q;
      pprio1_d = pprio1_q;
      pprio2_d = pprio2_q;
      res_hi_d = res_hi_q;
      res_lo_d = res_lo_q;
      if (i_wr)
      begin
         case (i_addr)
            OFF_RES_HI: res_hi_d = i_wdata;
            OFF_RES_LO: res_lo_d = i_wdata;
            OFF_CTRL_FIRST: ctrl0_d = i_wdata & CTRL_FIRST_WMASK;
            OFF_CTRL_SECOND: ctrl1_d = i_wdata & CTRL_SECOND_WMASK;
            OFF_PFLAGS1: pflags_d = i_wdata;
            OFF_PENABLES1: pen_d = i_wdata;
            OFF_PPRIO1: pprio1_d = i_wdata;
            OFF_PPRIO2: pprio2_d = i_wdata[4:0];
            default: ;
         endcase
      end
      // Reading the flag register clears it
      if (i_rd && (i_addr == OFF_PFLAGS1))
         pflags_d = 8'h00;
      // result load, go clear and flag in one cycle
      if (done)
      begin
         if (ctrl1_q[CS_JUSTIFY])
         begin
            res_hi_d = {6'h00, i_sample_data[9:8]};
            res_lo_d = i_sample_data[7:0];
         end
         else
         begin
            res_hi_d = i_sample_data[9:2];
            res_lo_d = {i_sample_data[1:0], 6'h00};
         end
         ctrl0_d[CF_GO] = 1'b0;
         pflags_d[IRQ_BIT] = 1'b1;
      end
      if (trig_accept)
         ctrl0_d[CF_GO] = 1'b1;
      // Go cannot stand while the converter is off
      if (!ctrl0_d[CF_ON])
         ctrl0_d[CF_GO] = 1'b0;
   end

   // Control and interrupt registers
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ctrl0_q <= CTRL_FIRST_RST;
         ctrl1_q <= CTRL_SECOND_RST;
         // flag register clears on any reset
         pflags_q <= PFLAGS1_RST;
         pen_q <= PENABLES1_RST;
         pprio1_q <= PPRIO1_RST;
         // reset value depends on reset kind
         pprio2_q <= i_por_bor ? PPRIO2_RST_POR : PPRIO2_RST_OTHER;
      end
      else if (i_ce)
      begin
         ctrl0_q <= ctrl0_d;
         ctrl1_q <= ctrl1_d;
         pflags_q <= pflags_d;
         pen_q <= pen_d;
         pprio1_q <= pprio1_d;
         pprio2_q <= pprio2_d;
      end
   end

   // Result bytes carry no reset so software data survive warm resets
   // results untouched by reset
   always_ff @(posedge i_clk)
   begin
      if (i_ce && !i_srst)
      begin
         res_hi_q <= res_hi_d;
         res_lo_q <= res_lo_d;
      end
   end

   // Read mux; unmapped indices and idle cycles read zero
   always_comb
   begin
      rdata_d = 8'h00;
      if (i_rd)
      begin
         case (i_addr)
            OFF_RES_HI: rdata_d = res_hi_q;
            OFF_RES_LO: rdata_d = res_lo_q;
            OFF_CTRL_FIRST: rdata_d = ctrl0_q;
            OFF_CTRL_SECOND: rdata_d = ctrl1_q;
            OFF_PFLAGS1: rdata_d = pflags_q;
            OFF_PENABLES1: rdata_d = pen_q;
            OFF_PPRIO1: rdata_d = pprio1_q;
            OFF_PPRIO2: rdata_d = {3'h0, pprio2_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Output flops, all but timer clear and read data fed from next values so they track the registers
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_rdata <= 8'h00;
         o_timer_clear <= 1'b0;
         o_sampling <= 1'b0;
         o_converting <= 1'b0;
         o_channel <= 3'h0;
         o_port_config <= 4'h0;
         o_irq <= 1'b0;
         o_irq_high_prio <= 1'b0;
      end
      else if (i_ce)
      begin
         o_rdata <= rdata_d;
         o_timer_clear <= trig_event;
         o_sampling <= (st_d == ST_ACQ);
         o_converting <= (st_d == ST_CONV);
         o_channel <= ctrl0_d[CF_CHS_HI:CF_CHS_LO];
         o_port_config <= ctrl1_d[CS_PCFG_HI:CS_PCFG_LO];
         o_irq <= pflags_d[IRQ_BIT] & pen_d[IRQ_BIT];
         o_irq_high_prio <= pprio1_d[IRQ_BIT];
      end
   end

   // Cycles in the current state, kept apart from the tick logic
   assign dwell_d = (st_d != st_q) ? 12'h000 : dwell_q + 12'h001;
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         dwell_q <= 12'h000;
      else if (i_ce)
         dwell_q <= dwell_d;
   end

   default clocking adctr_cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   a_trig_sets_go: assert property (
      i_ce && trig_accept |=> ctrl0_q[CF_GO] || !ctrl0_q[CF_ON])
      else $error("accepted trigger did not set go");
   a_off_ignores_trig: assert property (
      i_ce && trig_event && !ctrl0_q[CF_ON] && !wr_ctrl0
      |=> !ctrl0_q[CF_GO] && o_timer_clear)
      else $error("trigger while off changed go or missed timer clear");
   a_timer_clear_pulse: assert property (
      i_ce && trig_event |=> o_timer_clear)
      else $error("timer clear missing after trigger");
   a_ctrl_first_bit1: assert property (
      i_ce && i_rd && (i_addr == OFF_CTRL_FIRST) |=> !o_rdata[CF_ZERO])
      else $error("first control bit 1 read as one");
   a_ctrl_second_gap: assert property (
      i_ce && i_rd && (i_addr == OFF_CTRL_SECOND) |=> o_rdata[5:4] == 2'h0)
      else $error("second control bits 5-4 not zero");
   a_results_warm_rst: assert property (
      disable iff (1'b0)
      i_srst && !i_por_bor |=> $stable(res_hi_q) && $stable(res_lo_q))
      else $error("result bytes changed across reset");
   a_flags_reset_zero: assert property (
      disable iff (1'b0)
      i_srst |=> pflags_q == PFLAGS1_RST && pen_q == PENABLES1_RST
         && pprio1_q == PPRIO1_RST)
      else $error("flag, enable or priority not zero after reset");
   a_pprio2_reset: assert property (
      disable iff (1'b0)
      i_srst |=> pprio2_q == ($past(i_por_bor) ? PPRIO2_RST_POR
         : PPRIO2_RST_OTHER))
      else $error("second priority reset value wrong");
   a_conv_length: assert property (
      i_ce && done
      |-> dwell_q == {4'h0, tad_len} * {8'h00, CONV_TADS} - 12'h001)
      else $error("conversion ended at wrong bit period");
   a_abort_keeps_res: assert property (
      i_ce && abort && !wr_res
      |=> $stable(res_hi_q) && $stable(res_lo_q) && st_q != ST_CONV)
      else $error("abort altered results or stayed converting");
   a_wait_two_tads: assert property (
      i_ce && (st_q == ST_WAIT) && (st_d == ST_ACQ)
      |-> dwell_q == {3'h0, tad_len, 1'b0} - 12'h001)
      else $error("acquisition resumed before two bit periods");
   a_done_flags: assert property (
      i_ce && done && !trig_accept
      |=> pflags_q[IRQ_BIT] && !ctrl0_q[CF_GO] && st_q == ST_WAIT)
      else $error("completion did not set flag and clear go together");
   a_irq_tracks_mask: assert property (
      i_ce |=> o_irq == (pflags_q[IRQ_BIT] & pen_q[IRQ_BIT]))
      else $error("interrupt output does not follow flag and enable");

endmodule : adctr_top

/* adctr_cmp_model.sv */
// Compare unit and timer model on the far side of the trigger input
`timescale 1ns/100ps

module adctr_cmp_model #(
   parameter int PERIOD = 40
)
(
   input wire logic i_clk, // Clock
   input wire logic i_srst, // Synchronous reset, high
   input wire logic i_arm, // Allow compare matches
   input wire logic i_timer_clear, // Clear from the converter
   output logic o_event, // Special-event pulse
   output logic [7:0] o_count // Timer counter
);
   logic [7:0] count_d;
   logic [7:0] count_q;
   logic event_d;
   logic event_q;

   // Match fires once as the count passes the period; 8 bits wrap fast
   always_comb
   begin
      event_d = i_arm && (count_q == 8'(PERIOD));
      count_d = count_q + 8'h01;
      if (i_timer_clear)
      begin
         count_d = 8'h00;
      end
   end

   // Registers of the model
   always_ff @(posedge i_clk)
   begin
      count_q <= i_srst ? 8'h00 : count_d;
      event_q <= i_srst ? 1'b0 : event_d;
   end

   assign o_event = event_q;
   assign o_count = count_q;
endmodule : adctr_cmp_model

/* tb_adctr_top.sv */
// Self-checking bench for the converter trigger and control block
`timescale 1ns/100ps

module tb_adctr_top;
   import adctr_pkg::*;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_por_bor = 1'b1;
   logic i_ce = 1'b1;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [3:0] i_cmp_mode = 4'h0;
   logic [9:0] i_sample_data = 10'h000;
   logic arm = 1'b0;
   logic i_cmp_event, o_timer_clear, o_sampling, o_converting;
   logic o_irq, o_irq_high_prio;
   logic [7:0] o_rdata, tmr;
   logic [2:0] o_channel;
   logic [3:0] o_port_config;
   int err_total = 0;
   int check_count = 0;
   int t, n;
   logic [15:0] last;
   logic [31:0] seed = 32'h99f77da9;
   // Address, write value, value read back
   logic [19:0] tbl [8] = '{20'h0a5a5, 20'h15a5a, 20'h2fcf8, 20'h3ffcf,
      20'h54040, 20'h64040, 20'h7ff1f, 20'h9ff00};
   wire logic [2:0] st = {o_converting, o_timer_clear, o_sampling};

   // 25 ns clock
   always #12.5 i_clk = ~i_clk;

   adctr_top u_adctr_top (.i_clk(i_clk), .i_srst(i_srst),
      .i_por_bor(i_por_bor), .i_ce(i_ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_cmp_mode(i_cmp_mode), .i_cmp_event(i_cmp_event),
      .i_sample_data(i_sample_data), .o_timer_clear(o_timer_clear),
      .o_sampling(o_sampling), .o_converting(o_converting),
      .o_channel(o_channel), .o_port_config(o_port_config),
      .o_irq(o_irq), .o_irq_high_prio(o_irq_high_prio));

   adctr_cmp_model u_adctr_cmp_model (.i_clk(i_clk), .i_srst(i_srst),
      .i_arm(arm), .i_timer_clear(o_timer_clear), .o_event(i_cmp_event),
      .o_count(tmr));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // Bit period in clocks; the RC source ignores the third select bit
   function automatic int conversion_bit_period(input logic [1:0] c, input logic c2);
      return (c == 2'h3) ? 160 : (1 << (1 + 2 * c + c2));
   endfunction : conversion_bit_period

   function automatic logic [15:0] res(input logic j, input logic [9:0] d);
      return j ? {6'h0, d} : {d, 6'h0};
   endfunction : res

   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   // Read data only stand in the cycle after the strobe
   task automatic rc(input string nm, input logic [3:0] a,
      input logic [7:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(nm, {8'h0, e}, {8'h0, o_rdata});
   endtask : rc

   // Bounded wait on one status output, cycles counted
   task automatic wait_for(input int sel, input int lim, output int c);
      c = 0;
      #1;
      while (st[sel] !== 1'b1 && c < lim)
      begin
         @(posedge i_clk);
         #1;
         c++;
      end
   endtask : wait_for

   task automatic print_verdict;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   // Watchdog well beyond the longest conversion sweep
   initial
   begin
      #(25 * 40000);
      err_total++;
      print_verdict();
   end

   // Main sequence
   initial
   begin
      repeat (16) @(posedge i_clk);
      i_srst <= 1'b0;
      rc("ctrl1 rst", OFF_CTRL_FIRST, 8'h00);
      rc("ctrl2 rst", OFF_CTRL_SECOND, 8'h00);
      rc("flags rst", OFF_PFLAGS1, 8'h00);
      rc("en rst", OFF_PENABLES1, 8'h00);
      rc("prio1 rst", OFF_PPRIO1, 8'h00);
      rc("prio2 rst", OFF_PPRIO2, 8'h1f);
      for (int i = 0; i < 8; i++)
      begin
         wr(tbl[i][19:16], tbl[i][15:8]);
         rc("reg rw", tbl[i][19:16], tbl[i][7:0]);
      end
      chk("prio out", 16'h1, {15'h0, o_irq_high_prio});
      // Every clock select, started by trigger or by software
      for (int k = 0; k < 8; k++)
      begin
         seed = xs(seed);
         t = conversion_bit_period(k[2:1], k[0]);
         wr(OFF_CTRL_SECOND, {seed[31], k[0], 2'h0, seed[15:12]});
         i_sample_data <= seed[9:0];
         i_cmp_mode <= TRIG_MODE;
         wr(OFF_PENABLES1, {1'b0, k[1], 6'h0});
         wr(OFF_CTRL_FIRST, {k[2:1], seed[18:16], 3'h1});
         wait_for(0, 2000, n); // acquire before any start
         if (k[0] ^ k[1])
         begin
            arm <= 1'b1;
            wait_for(1, 300, n);
            arm <= 1'b0;
            chk("tclr", 16'h1, {15'h0, o_timer_clear});
            @(posedge i_clk);
            #1;
            chk("timer", 16'h0, {8'h0, tmr});
         end
         else
         begin
            wr(OFF_CTRL_FIRST, {k[2:1], seed[18:16], 3'h5});
         end
         wait_for(2, 8, n);
         chk("start", 16'h1, {15'h0, o_converting});
         n = 0;
         while (o_converting === 1'b1 && n < 4000)
         begin
            @(posedge i_clk);
            #1;
            n++;
         end
         chk("conv len", 16'(12 * t), 16'(n));
         wait_for(0, 400, n);
         chk("wait len", 16'(2 * t), 16'(n));
         chk("irq", {15'h0, k[1]}, {15'h0, o_irq});
         rc("flag", OFF_PFLAGS1, 8'h40);
         rc("flag clr", OFF_PFLAGS1, 8'h00);
         chk("irq clr", 16'h0, {15'h0, o_irq});
         rc("go done", OFF_CTRL_FIRST, {k[2:1], seed[18:16], 3'h1});
         last = res(seed[31], seed[9:0]);
         rc("res hi", OFF_RES_HI, last[15:8]);
         rc("res lo", OFF_RES_LO, last[7:0]);
         chk("chan", {13'h0, seed[18:16]}, {13'h0, o_channel});
         chk("pcfg", {12'h0, seed[15:12]}, {12'h0, o_port_config});
      end
      // Abort mid-conversion keeps the old result
      wr(OFF_CTRL_FIRST, 8'h01);
      i_sample_data <= ~i_sample_data;
      wait_for(0, 400, n);
      wr(OFF_CTRL_FIRST, 8'h05);
      repeat (8) @(posedge i_clk);
      wr(OFF_CTRL_FIRST, 8'h01);
      repeat (4) @(posedge i_clk);
      #1;
      chk("aborted", 16'h0, {15'h0, o_converting});
      rc("abort hi", OFF_RES_HI, last[15:8]);
      rc("abort lo", OFF_RES_LO, last[7:0]);
      rc("abort flag", OFF_PFLAGS1, 8'h00);
      // Converter off: timer still cleared, go untouched
      wr(OFF_CTRL_FIRST, 8'h00);
      i_cmp_mode <= TRIG_MODE;
      arm <= 1'b1;
      wait_for(1, 300, n);
      arm <= 1'b0;
      chk("off tclr", 16'h1, {15'h0, o_timer_clear});
      rc("off go", OFF_CTRL_FIRST, 8'h00);
      // Wrong compare mode starts nothing and clears nothing
      wr(OFF_CTRL_FIRST, 8'h01);
      i_cmp_mode <= (seed[3:0] == TRIG_MODE) ? 4'h3 : seed[3:0];
      arm <= 1'b1;
      n = 0;
      repeat (300)
      begin
         @(posedge i_clk);
         #1;
         n += (st[2:1] !== 2'h0) ? 1 : 0;
      end
      arm <= 1'b0;
      chk("bad mode", 16'h0, 16'(n));
      // Clock enable low freezes the registers
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(OFF_PPRIO1, 8'h00);
      i_ce <= 1'b1;
      rc("ce hold", OFF_PPRIO1, 8'h40);
      chk("ce prio", 16'h1, {15'h0, o_irq_high_prio});
      // Warm reset keeps results
      @(posedge i_clk);
      i_por_bor <= 1'b0;
      i_srst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      rc("prio2 warm", OFF_PPRIO2, 8'h10);
      rc("hi kept", OFF_RES_HI, last[15:8]);
      rc("lo kept", OFF_RES_LO, last[7:0]);
      rc("ctrl1 warm", OFF_CTRL_FIRST, 8'h00);
      print_verdict();
   end
endmodule : tb_adctr_top
